// >>> verilog/slk_supervisor.sv
// Serial link supervisor: loss timeout, stop reaction, response wait,
// RTS, run word decode, voltage monitor scaling and Enter-gated commits.
// Assumes frame decoder, transmitter and settings share the one clock.
`timescale 1ns/10ps

// Functional notes
// - On link fault apply stop reaction: ramp, coast, fast, alarm, preset speed.
// - Detection enable: 0 no link-loss fault, 1 supervision on.
// - No master data longer than detection time raises fault, then reaction.
// - Detection time 0.0 to 10.0 s in tenths, default 2.0 s.
// - Response waits 5 to 65 ms after a message, default 5 ms.
// - Wait time and RTS control sampled only once after power-up.
// - RTS control 0 keeps RTS on; 1 asserts only while sending.
// - Protocol code 0 Modbus default, 1 and 2 automation, 3 BACnet.
// - Voltage monitor register OUTPUT_VOLTAGE_MONITOR in 0.1 V or 1 V units.
// - Commit setting 0 holds parameter writes until one Enter command; code stages at most 4 and drops writes beyond that.
// - Commit setting 1 makes each written parameter effective at once.
// - Method 0: run word bit 0 forward run, bit 1 reverse run.
// - Method 1: bit 0 run or stop, bit 1 selects direction.
// - Parity 0 none, 1 even, 2 odd; taken only at power-up.
module slk_supervisor #(
  parameter int MS_CYC = slk_pkg::MS_CYC,
  parameter int TENTH_CYC = slk_pkg::TENTH_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [2:0] comm_error_stop_method,
  input wire logic comm_loss_detect_enable,
  input wire logic [6:0] transmit_wait_time,
  input wire logic transmit_enable_control,
  input wire logic [1:0] protocol_select,
  input wire logic [6:0] comm_loss_detect_time,
  input wire logic voltage_monitor_unit,
  input wire logic enter_commit_select,
  input wire logic run_method_select,
  input wire logic [1:0] parity_select,
  input wire logic [1:0] run_source_select,
  input wire logic fault_reset,
  input wire logic msg_valid,
  input wire logic resp_req,
  input wire logic tx_done,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] vout_dv,
  input wire logic param_wr,
  input wire logic [15:0] param_addr,
  input wire logic [15:0] param_data,
  input wire logic enter_cmd,
  output logic ce_fault,
  output logic [2:0] stop_mode,
  output logic motor_run,
  output logic motor_rev,
  output logic preset_sel,
  output logic tx_start,
  output logic rts,
  output logic [1:0] parity_mode,
  output logic [1:0] protocol,
  output logic [15:0] rd_data,
  output logic rd_ack,
  output logic cmt_valid,
  output logic [15:0] cmt_addr,
  output logic [15:0] cmt_data,
  output logic stage_full
);

  slk_tick_if tk ();

  slk_tick #(.MS_CYC(MS_CYC), .TENTH_CYC(TENTH_CYC)) u_tick (
    .clock(clock),
    .arst_n(arst_n),
    .tk(tk.gen)
  );

  // Power-up captured settings
  logic cap_done_ff, nxt_cap_done;
  logic [6:0] wait_lat_ff, nxt_wait_lat;
  logic rts_lat_ff, nxt_rts_lat;
  logic [1:0] parity_ff, nxt_parity;
  // Loss supervision
  logic [6:0] loss_cnt_ff, nxt_loss_cnt;
  logic fault_ff, nxt_fault;
  logic [6:0] time_lim;
  // Response timing
  slk_pkg::slk_tx_t state_ff, nxt_state;
  logic [6:0] wcnt_ff, nxt_wcnt;
  logic tx_start_ff, nxt_tx_start;
  logic rts_ff, nxt_rts;
  // Run word and drive outputs
  logic [15:0] run_word_ff, nxt_run_word;
  logic run_ff, nxt_run, rev_ff, nxt_rev, preset_ff, nxt_preset;
  logic [2:0] stop_mode_ff, nxt_stop_mode;
  logic [1:0] proto_ff, nxt_proto;
  logic modbus, run_req, rev_req, halt;
  // Register reads
  logic [15:0] rd_data_ff, nxt_rd_data;
  logic rd_ack_ff, nxt_rd_ack;
  // Commit staging
  logic [15:0] stg_addr_ff [slk_pkg::STAGE_DEPTH];
  logic [15:0] stg_data_ff [slk_pkg::STAGE_DEPTH];
  logic [15:0] nxt_stg_addr [slk_pkg::STAGE_DEPTH];
  logic [15:0] nxt_stg_data [slk_pkg::STAGE_DEPTH];
  logic [2:0] stg_cnt_ff, nxt_stg_cnt;
  logic drain_ff, nxt_drain;
  logic cmt_valid_ff, nxt_cmt_valid;
  logic [15:0] cmt_addr_ff, nxt_cmt_addr, cmt_data_ff, nxt_cmt_data;
  logic full_ff, nxt_full;
  logic push, pop;

  assign modbus = (proto_ff == slk_pkg::PROTO_MODBUS);

  always_comb begin
    nxt_cap_done = 1'b1;
    nxt_wait_lat = wait_lat_ff;
    nxt_rts_lat = rts_lat_ff;
    nxt_parity = parity_ff;
    if (!cap_done_ff) begin
      nxt_rts_lat = transmit_enable_control;
      nxt_parity = parity_select;
      if (transmit_wait_time < slk_pkg::WAIT_MIN_MS) begin
        nxt_wait_lat = slk_pkg::WAIT_MIN_MS;
      end else if (transmit_wait_time > slk_pkg::WAIT_MAX_MS) begin
        nxt_wait_lat = slk_pkg::WAIT_MAX_MS;
      end else begin
        nxt_wait_lat = transmit_wait_time;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cap_done_ff <= 1'b0;
      wait_lat_ff <= slk_pkg::WAIT_DEF_MS;
      rts_lat_ff <= slk_pkg::RTS_CTRL_DEF;
      parity_ff <= slk_pkg::PARITY_DEF;
    end else begin
      cap_done_ff <= nxt_cap_done;
      wait_lat_ff <= nxt_wait_lat;
      rts_lat_ff <= nxt_rts_lat;
      parity_ff <= nxt_parity;
    end
  end

  always_comb begin
    // detection time in tenths, capped at 10.0 s
    time_lim = (comm_loss_detect_time > slk_pkg::DET_TIME_MAX) ?
      slk_pkg::DET_TIME_MAX : comm_loss_detect_time;
    tk.tenth_clr = msg_valid;
    nxt_loss_cnt = loss_cnt_ff;
    // restart per message, idle when disabled
    if (msg_valid || !comm_loss_detect_enable) begin
      nxt_loss_cnt = 7'h00;
    end else if (tk.tenth_tick && loss_cnt_ff <= time_lim) begin
      nxt_loss_cnt = loss_cnt_ff + 7'h01;
    end
    // fault when silence exceeds limit; set beats clear
    nxt_fault = (fault_ff & ~fault_reset) |
      (comm_loss_detect_enable & (loss_cnt_ff > time_lim));
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_wcnt = wcnt_ff;
    nxt_tx_start = 1'b0;
    tk.ms_clr = 1'b0;
    case (state_ff)
      slk_pkg::TX_IDLE: begin
        if (msg_valid && resp_req) begin
          nxt_state = slk_pkg::TX_WAIT;
          nxt_wcnt = 7'h00;
          tk.ms_clr = 1'b1;
        end
      end
      slk_pkg::TX_WAIT: begin
        // hold response for the set wait
        if (wcnt_ff == wait_lat_ff) begin
          nxt_state = slk_pkg::TX_XMIT;
          nxt_tx_start = 1'b1;
        end else if (tk.ms_tick) begin
          nxt_wcnt = wcnt_ff + 7'h01;
        end
      end
      slk_pkg::TX_XMIT: begin
        if (tx_done) begin
          nxt_state = slk_pkg::TX_IDLE;
        end
      end
      default: begin
        nxt_state = slk_pkg::TX_IDLE;
      end
    endcase
    nxt_rts = ~rts_lat_ff | (nxt_state == slk_pkg::TX_XMIT);
  end

  always_comb begin
    nxt_proto = protocol_select;
    nxt_run_word = run_word_ff;
    if (reg_wr && reg_addr == slk_pkg::RUN_WORD_ADDR && modbus &&
        run_source_select == slk_pkg::RUN_SRC_SERIAL) begin
      nxt_run_word = reg_wdata;
    end
    if (run_method_select) begin
      run_req = run_word_ff[0];
      rev_req = run_word_ff[1];
    end else begin
      run_req = run_word_ff[0] ^ run_word_ff[1];
      rev_req = run_word_ff[1] & ~run_word_ff[0];
    end
    halt = fault_ff && comm_error_stop_method <= slk_pkg::STOP_FAST;
    nxt_run = run_req & ~halt & (run_source_select == slk_pkg::RUN_SRC_SERIAL);
    nxt_rev = rev_req;
    nxt_preset = fault_ff && comm_error_stop_method == slk_pkg::STOP_PRESET;
    nxt_stop_mode = (comm_error_stop_method > slk_pkg::STOP_PRESET) ?
      slk_pkg::STOP_ALARM : comm_error_stop_method;
    nxt_rd_ack = reg_rd;
    nxt_rd_data = 16'h0000;
    if (reg_rd && reg_addr == slk_pkg::RUN_WORD_ADDR) begin
      nxt_rd_data = run_word_ff;
    end else if (reg_rd && reg_addr == slk_pkg::VMON_ADDR && modbus) begin
      nxt_rd_data = voltage_monitor_unit ? (vout_dv / slk_pkg::VMON_DIV) : vout_dv;
    end
  end

  always_comb begin
    pop = drain_ff && stg_cnt_ff != 3'h0;
    // stage writes while Enter is required
    push = param_wr && modbus && !enter_commit_select &&
      (stg_cnt_ff != slk_pkg::STAGE_DEPTH_W || pop);
    for (int i = 0; i < slk_pkg::STAGE_DEPTH; i++) begin
      nxt_stg_addr[i] = stg_addr_ff[i];
      nxt_stg_data[i] = stg_data_ff[i];
      if (pop && i < slk_pkg::STAGE_DEPTH - 1) begin
        nxt_stg_addr[i] = stg_addr_ff[i + 1];
        nxt_stg_data[i] = stg_data_ff[i + 1];
      end
      if (push && 3'(i) == stg_cnt_ff - {2'b00, pop}) begin
        nxt_stg_addr[i] = param_addr;
        nxt_stg_data[i] = param_data;
      end
    end
    nxt_stg_cnt = stg_cnt_ff - {2'b00, pop} + {2'b00, push};
    nxt_drain = (drain_ff | (enter_cmd & ~enter_commit_select)) & (nxt_stg_cnt != 3'h0);
    nxt_full = (nxt_stg_cnt == slk_pkg::STAGE_DEPTH_W);
    nxt_cmt_valid = 1'b0;
    nxt_cmt_addr = cmt_addr_ff;
    nxt_cmt_data = cmt_data_ff;
    if (param_wr && modbus && enter_commit_select) begin
      nxt_cmt_valid = 1'b1;
      nxt_cmt_addr = param_addr;
      nxt_cmt_data = param_data;
    end else if (pop) begin
      nxt_cmt_valid = 1'b1;
      nxt_cmt_addr = stg_addr_ff[0];
      nxt_cmt_data = stg_data_ff[0];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      loss_cnt_ff <= 7'h00;
      fault_ff <= 1'b0;
      state_ff <= slk_pkg::TX_IDLE;
      wcnt_ff <= 7'h00;
      tx_start_ff <= 1'b0;
      rts_ff <= 1'b0;
      proto_ff <= slk_pkg::PROTO_MODBUS;
      run_word_ff <= 16'h0000;
      run_ff <= 1'b0;
      rev_ff <= 1'b0;
      preset_ff <= 1'b0;
      stop_mode_ff <= slk_pkg::STOP_ALARM;
      rd_data_ff <= 16'h0000;
      rd_ack_ff <= 1'b0;
      for (int i = 0; i < slk_pkg::STAGE_DEPTH; i++) begin
        stg_addr_ff[i] <= 16'h0000;
        stg_data_ff[i] <= 16'h0000;
      end
      stg_cnt_ff <= 3'h0;
      drain_ff <= 1'b0;
      full_ff <= 1'b0;
      cmt_valid_ff <= 1'b0;
      cmt_addr_ff <= 16'h0000;
      cmt_data_ff <= 16'h0000;
    end else begin
      loss_cnt_ff <= nxt_loss_cnt;
      fault_ff <= nxt_fault;
      state_ff <= nxt_state;
      wcnt_ff <= nxt_wcnt;
      tx_start_ff <= nxt_tx_start;
      rts_ff <= nxt_rts;
      proto_ff <= nxt_proto;
      run_word_ff <= nxt_run_word;
      run_ff <= nxt_run;
      rev_ff <= nxt_rev;
      preset_ff <= nxt_preset;
      stop_mode_ff <= nxt_stop_mode;
      rd_data_ff <= nxt_rd_data;
      rd_ack_ff <= nxt_rd_ack;
      stg_addr_ff <= nxt_stg_addr;
      stg_data_ff <= nxt_stg_data;
      stg_cnt_ff <= nxt_stg_cnt;
      drain_ff <= nxt_drain;
      full_ff <= nxt_full;
      cmt_valid_ff <= nxt_cmt_valid;
      cmt_addr_ff <= nxt_cmt_addr;
      cmt_data_ff <= nxt_cmt_data;
    end
  end

  assign ce_fault = fault_ff;
  assign stop_mode = stop_mode_ff;
  assign motor_run = run_ff;
  assign motor_rev = rev_ff;
  assign preset_sel = preset_ff;
  assign tx_start = tx_start_ff;
  assign rts = rts_ff;
  assign parity_mode = parity_ff;
  assign protocol = proto_ff;
  assign rd_data = rd_data_ff;
  assign rd_ack = rd_ack_ff;
  assign cmt_valid = cmt_valid_ff;
  assign cmt_addr = cmt_addr_ff;
  assign cmt_data = cmt_data_ff;
  assign stage_full = full_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence tx_req_s;
    state_ff == slk_pkg::TX_IDLE && msg_valid && resp_req;
  endsequence
  sequence wait_full_s;
    state_ff == slk_pkg::TX_WAIT && wcnt_ff == wait_lat_ff;
  endsequence

  loss_fault_a: assert property (
    comm_loss_detect_enable && loss_cnt_ff > time_lim |=> fault_ff)
    else $error("link loss did not raise fault");
  detect_off_a: assert property (
    !comm_loss_detect_enable && (!fault_ff || fault_reset) |=> !fault_ff)
    else $error("fault set while detection off");
  loss_restart_a: assert property (
    msg_valid |=> loss_cnt_ff == 7'h00)
    else $error("loss timer not restarted");
  coast_stop_a: assert property (
    fault_ff && comm_error_stop_method == slk_pkg::STOP_COAST |=> !run_ff && !preset_ff)
    else $error("coast reaction left motor running");
  tx_wait_a: assert property (
    tx_req_s |=> (state_ff == slk_pkg::TX_WAIT && !tx_start_ff) [*2])
    else $error("response started without wait");
  tx_go_a: assert property (
    wait_full_s |=> tx_start_ff && state_ff == slk_pkg::TX_XMIT)
    else $error("response not started after wait");
  sample_hold_a: assert property (
    cap_done_ff |=> $stable(wait_lat_ff) && $stable(rts_lat_ff) && $stable(parity_ff))
    else $error("power-up setting changed");
  rts_mode_a: assert property (
    cap_done_ff && $past(cap_done_ff) |-> rts_ff == (!rts_lat_ff || state_ff == slk_pkg::TX_XMIT))
    else $error("RTS level wrong for mode");
  enter_hold_a: assert property (
    cmt_valid_ff |-> $past(drain_ff) || $past(enter_commit_select))
    else $error("commit without Enter");
  direct_cmt_a: assert property (
    param_wr && modbus && enter_commit_select |=> cmt_valid_ff && cmt_data_ff == $past(param_data))
    else $error("direct write not committed");
  fwd_run_a: assert property (
    !run_method_select && run_word_ff[1:0] == 2'b01 && !fault_ff &&
    run_source_select == slk_pkg::RUN_SRC_SERIAL |=> run_ff && !rev_ff)
    else $error("forward run bit not obeyed");
  vmon_unit_a: assert property (
    reg_rd && reg_addr == slk_pkg::VMON_ADDR && modbus && !voltage_monitor_unit
    |=> rd_ack_ff && rd_data_ff == $past(vout_dv))
    else $error("voltage monitor unit wrong");

endmodule

// >>> verilog/slk_pkg.sv
// Constants, codes and types for the serial link supervisor.
// Assumes a single 20 MHz clock; all settings arrive on the same clock.
package slk_pkg;

  localparam int CLK_HZ = 20_000_000;
  // Time base steps in milliseconds
  localparam int MS_STEP_MS = 1;
  localparam int TENTH_STEP_MS = 100;
  localparam int MS_CYC = CLK_HZ / 1000 * MS_STEP_MS;
  localparam int TENTH_CYC = CLK_HZ / 1000 * TENTH_STEP_MS;

  // Register offsets on the link and the voltage monitor divisor
  localparam logic [15:0] RUN_WORD_ADDR = 16'h0001;
  localparam logic [15:0] VMON_ADDR = 16'h0025;
  localparam logic [15:0] VMON_DIV = 16'h000A;

  // Stop reaction codes
  localparam logic [2:0] STOP_RAMP = 3'h0;
  localparam logic [2:0] STOP_COAST = 3'h1;
  localparam logic [2:0] STOP_FAST = 3'h2;
  localparam logic [2:0] STOP_ALARM = 3'h3;
  localparam logic [2:0] STOP_PRESET = 3'h4;

  localparam logic [1:0] PROTO_MODBUS = 2'h0;
  localparam logic [1:0] RUN_SRC_SERIAL = 2'h2;

  // Settings limits and power-up defaults
  localparam logic [6:0] WAIT_MIN_MS = 7'h05;
  localparam logic [6:0] WAIT_MAX_MS = 7'h41;
  localparam logic [6:0] WAIT_DEF_MS = 7'h05;
  localparam logic [6:0] DET_TIME_MAX = 7'h64;
  localparam logic RTS_CTRL_DEF = 1'b1;
  localparam logic [1:0] PARITY_DEF = 2'h0;

  localparam int STAGE_DEPTH = 4;
  localparam logic [2:0] STAGE_DEPTH_W = 3'h4;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_XMIT = 2'b10
  } slk_tx_t;

endpackage

// >>> verilog/slk_tick_if.sv
// Time base ticks and their restart requests.
// Assumes both ends share the one system clock.
`timescale 1ns/10ps
interface slk_tick_if;
  logic ms_clr;
  logic tenth_clr;
  logic ms_tick;
  logic tenth_tick;
  modport gen (input ms_clr, input tenth_clr, output ms_tick, output tenth_tick);
  modport use_tick (output ms_clr, output tenth_clr, input ms_tick, input tenth_tick);
endinterface

// >>> verilog/slk_tick.sv
// Millisecond and tenth-second enable pulses, each restartable.
// Assumes clear requests come from logic on the same clock.
`timescale 1ns/10ps
module slk_tick #(
  parameter int MS_CYC = slk_pkg::MS_CYC,
  parameter int TENTH_CYC = slk_pkg::TENTH_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  slk_tick_if.gen tk
);

  logic [21:0] ms_cnt_ff;
  logic [21:0] tenth_cnt_ff;
  logic ms_tick_ff;
  logic tenth_tick_ff;
  logic [21:0] nxt_ms_cnt;
  logic [21:0] nxt_tenth_cnt;
  logic nxt_ms_tick;
  logic nxt_tenth_tick;

  always_comb begin
    nxt_ms_tick = 1'b0;
    nxt_tenth_tick = 1'b0;
    nxt_ms_cnt = ms_cnt_ff + 22'h000001;
    nxt_tenth_cnt = tenth_cnt_ff + 22'h000001;
    if (tk.ms_clr) begin
      nxt_ms_cnt = 22'h000000;
    end else if (ms_cnt_ff == 22'(MS_CYC - 1)) begin
      nxt_ms_cnt = 22'h000000;
      nxt_ms_tick = 1'b1;
    end
    if (tk.tenth_clr) begin
      nxt_tenth_cnt = 22'h000000;
    end else if (tenth_cnt_ff == 22'(TENTH_CYC - 1)) begin
      nxt_tenth_cnt = 22'h000000;
      nxt_tenth_tick = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt_ff <= 22'h000000;
      tenth_cnt_ff <= 22'h000000;
      ms_tick_ff <= 1'b0;
      tenth_tick_ff <= 1'b0;
    end else begin
      ms_cnt_ff <= nxt_ms_cnt;
      tenth_cnt_ff <= nxt_tenth_cnt;
      ms_tick_ff <= nxt_ms_tick;
      tenth_tick_ff <= nxt_tenth_tick;
    end
  end

  assign tk.ms_tick = ms_tick_ff;
  assign tk.tenth_tick = tenth_tick_ff;

endmodule

// >>> tb/slk_master_model.sv
// Bus master model: message strobes plus the response transmitter.
// Assumes the supervisor samples on the rising edge of clock.
`timescale 1ns/10ps
module slk_master_model (
  input wire logic clock,
  input wire logic tx_start,
  input wire logic [7:0] tx_lat,
  output logic msg_valid,
  output logic resp_req,
  output logic tx_done
);
  int cnt;
  logic busy;

  initial begin
    msg_valid = 1'h0;
    resp_req = 1'h0;
    tx_done = 1'h0;
    busy = 1'h0;
    cnt = 0;
  end

  // One message strobe across one rising edge
  task automatic send(input logic want);
    @(negedge clock);
    msg_valid = 1'h1;
    resp_req = want;
    @(negedge clock);
    msg_valid = 1'h0;
    resp_req = 1'h0;
  endtask

  // Transmitter ends tx_lat plus one cycles after the start pulse
  always @(negedge clock) begin
    tx_done <= 1'h0;
    if (tx_start === 1'h1) begin
      busy <= 1'h1;
      cnt <= 0;
    end else if (busy) begin
      if (cnt >= int'(tx_lat)) begin
        tx_done <= 1'h1;
        busy <= 1'h0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// >>> tb/tb_serial_link_supervisor.sv
// Self-checking bench for the serial link supervisor.
// Assumes shortened time base: 10 cycles a ms, 50 cycles a tenth.
`timescale 1ns/10ps
module tb_serial_link_supervisor;
  localparam int MSC = 10;
  localparam int TNC = 50;
  logic clock, arst_n, comm_loss_detect_enable, transmit_enable_control;
  logic voltage_monitor_unit, enter_commit_select, run_method_select, fault_reset;
  logic msg_valid, resp_req, tx_done, reg_wr, reg_rd, param_wr, enter_cmd;
  logic [2:0] comm_error_stop_method, stop_mode;
  logic [6:0] transmit_wait_time, comm_loss_detect_time;
  logic [1:0] protocol_select, parity_select, run_source_select, parity_mode, protocol;
  logic [15:0] reg_addr, reg_wdata, vout_dv, param_addr, param_data, rd_data;
  logic [15:0] cmt_addr, cmt_data;
  logic ce_fault, motor_run, motor_rev, preset_sel, tx_start, rts, rd_ack, cmt_valid;
  logic stage_full;
  logic [7:0] tx_lat;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 32'hFFCD0377;
  int n, w1, w2;
  logic [15:0] v, qa[$], qd[$];
  logic [1:0] er;

  slk_supervisor #(.MS_CYC(MSC), .TENTH_CYC(TNC)) i_slk_supervisor (.*);
  slk_master_model i_slk_master_model (.clock(clock), .tx_start(tx_start),
    .tx_lat(tx_lat), .msg_valid(msg_valid), .resp_req(resp_req), .tx_done(tx_done));

  always #25 clock = ~clock;

  task automatic conclude;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return tx_start;
      1: return ce_fault;
      2: return cmt_valid;
      3: return rd_ack;
      default: return tx_done;
    endcase
  endfunction

  task automatic wait_sig(input int s, input int lim, output int k);
    k = 0;
    while (sig(s) !== 1'h1 && k < lim) begin
      @(negedge clock);
      k++;
    end
  endtask

  function automatic logic [1:0] exp_run(input logic m, input logic [1:0] b);
    if (m) return b;
    return {b == 2'h2, b == 2'h1 || b == 2'h2};
  endfunction

  function automatic logic [15:0] vmon(input logic [15:0] x, input logic u);
    return u ? x / 16'h000A : x;
  endfunction

  task automatic reg_acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    reg_acc(1'h0, a, 16'h0000);
    wait_sig(3, 3, n);
    chk("rd_ack", 16'h1, rd_ack);
    chk("rd_data", e, rd_data);
  endtask

  task automatic pwr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    param_wr = 1'h1;
    param_addr = a;
    param_data = d;
    @(negedge clock);
    param_wr = 1'h0;
  endtask

  task automatic pulse_enter;
    @(negedge clock);
    enter_cmd = 1'h1;
    @(negedge clock);
    enter_cmd = 1'h0;
  endtask

  task automatic do_reset(input logic ctl, input int w, input logic [1:0] par);
    @(negedge clock);
    arst_n = 1'h0;
    transmit_enable_control = ctl;
    transmit_wait_time = w[6:0];
    parity_select = par;
    cyc(6);
    chk("stop_mode", 16'h3, stop_mode);
    arst_n = 1'h1;
    cyc(3);
    chk("parity_mode", par, parity_mode);
    chk("rts_idle", !ctl, rts);
  endtask

  task automatic resp_test(input int w, input logic ctl);
    tx_lat = 8'($random(seed) & 7);
    i_slk_master_model.send(1'h1);
    wait_sig(0, 800, n);
    chk("wait_lo", 16'h1, n >= w * MSC);
    chk("wait_hi", 16'h1, n <= w * MSC + 5);
    chk("rts_tx", 16'h1, rts);
    wait_sig(4, 20, n);
    cyc(2);
    chk("rts_end", !ctl, rts);
  endtask

  task automatic loss_test(input logic [2:0] code, input logic [6:0] d);
    comm_error_stop_method = code;
    comm_loss_detect_time = d;
    i_slk_master_model.send(1'h0);
    fault_reset = 1'h1;
    @(negedge clock);
    fault_reset = 1'h0;
    chk("fault_clr", 16'h0, ce_fault);
    reg_acc(1'h1, 16'h0001, 16'h0001);
    cyc(2);
    chk("run_on", 16'h1, motor_run);
    wait_sig(1, 2000, n);
    n = n + 5;
    chk("loss_lo", 16'h1, n >= (d + 1) * TNC - 2);
    chk("loss_hi", 16'h1, n <= (d + 1) * TNC + 6);
    cyc(3);
    chk("fault_held", 16'h1, ce_fault);
    chk("stop_mode", code, stop_mode);
    chk("run_react", code > 3'h2, motor_run);
    chk("preset", code == 3'h4, preset_sel);
  endtask

  initial begin
    clock = 1'h0;
    arst_n = 1'h0;
    comm_error_stop_method = 3'h3;
    comm_loss_detect_enable = 1'h1;
    comm_loss_detect_time = 7'h64;
    transmit_wait_time = 7'h05;
    transmit_enable_control = 1'h1;
    protocol_select = 2'h0;
    parity_select = 2'h0;
    run_source_select = 2'h2;
    voltage_monitor_unit = 1'h0;
    enter_commit_select = 1'h1;
    run_method_select = 1'h0;
    fault_reset = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    vout_dv = 16'h0000;
    param_wr = 1'h0;
    param_addr = 16'h0000;
    param_data = 16'h0000;
    enter_cmd = 1'h0;
    tx_lat = 8'h00;
    w1 = 5 + {$random(seed)} % 61;
    do_reset(1'h1, w1, 2'h1);
    chk("fault_rst", 16'h0, ce_fault);
    resp_test(w1, 1'h1);
    transmit_wait_time = 7'h41;
    transmit_enable_control = 1'h0;
    parity_select = 2'h2;
    resp_test(w1, 1'h1);
    chk("parity_kept", 16'h1, parity_mode);
    for (int m = 0; m < 2; m++) begin
      for (int b = 0; b < 4; b++) begin
        run_method_select = m[0];
        reg_acc(1'h1, 16'h0001, 16'(b));
        cyc(2);
        er = exp_run(m[0], b[1:0]);
        chk("motor_run", er[0], motor_run);
        if (er[0]) chk("motor_rev", er[1], motor_rev);
      end
    end
    protocol_select = 2'h1;
    reg_acc(1'h1, 16'h0001, 16'h0000);
    run_source_select = 2'h0;
    protocol_select = 2'h0;
    reg_acc(1'h1, 16'h0001, 16'h0000);
    cyc(2);
    chk("run_src_off", 16'h0, motor_run);
    run_source_select = 2'h2;
    cyc(2);
    chk("run_refused", 16'h1, motor_run);
    for (int i = 0; i < 6; i++) begin
      v = 16'($random(seed));
      vout_dv = v;
      voltage_monitor_unit = i[0];
      rd_chk(16'h0025, vmon(v, i[0]));
    end
    rd_chk(16'h0100, 16'h0000);
    for (int p = 3; p >= 0; p--) begin
      protocol_select = p[1:0];
      cyc(2);
      chk("protocol", p[1:0], protocol);
      rd_chk(16'h0025, p == 0 ? vmon(v, 1'h1) : 16'h0000);
    end
    v = 16'($random(seed));
    pwr(16'h0123, v);
    wait_sig(2, 3, n);
    chk("cmt_now", v, cmt_data);
    pulse_enter;
    wait_sig(2, 4, n);
    chk("enter_ignored", 16'h4, n);
    enter_commit_select = 1'h0;
    for (int i = 0; i < 5; i++) begin
      qa.push_back(16'($random(seed)));
      qd.push_back(16'($random(seed)));
      pwr(qa[i], qd[i]);
      chk("cmt_held", 16'h0, cmt_valid);
      chk("stage_full", i >= 3, stage_full);
    end
    pulse_enter;
    for (int i = 0; i < 4; i++) begin
      wait_sig(2, 4, n);
      chk("cmt_addr", qa[i], cmt_addr);
      chk("cmt_data", qd[i], cmt_data);
      cyc(1);
    end
    wait_sig(2, 4, n);
    chk("cmt_dropped", 16'h4, n);
    for (int c = 0; c < 5; c++) begin
      loss_test(c[2:0], 7'({$random(seed)} % 3));
    end
    comm_loss_detect_enable = 1'h0;
    i_slk_master_model.send(1'h0);
    fault_reset = 1'h1;
    cyc(1);
    fault_reset = 1'h0;
    cyc(200);
    chk("no_detect", 16'h0, ce_fault);
    comm_loss_detect_enable = 1'h1;
    comm_loss_detect_time = 7'h64;
    w2 = 5 + {$random(seed)} % 61;
    do_reset(1'h0, w2, 2'h2);
    resp_test(w2, 1'h0);
    conclude;
  end

  initial begin
    #3000000;
    num_errors++;
    conclude;
  end
endmodule
